// ### ccc_far_model.sv
// Far-side model: analog input pins and timer capture unit
`timescale 1ns/1ps
`default_nettype none
module ccc_far_model (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic [3:0] raw_cmd_i,
  input  wire logic       edge_cmd_i,
  input  wire logic       cap_mask_i,
  input  wire logic       cap_evt_i,
  output logic [3:0]      cmp_raw_o,
  output logic            tmr_edge_sel_o,
  output logic [7:0]      cap_cnt_o
);
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmp_raw_o      <= 4'h0;
      tmr_edge_sel_o <= 1'b0;
      cap_cnt_o      <= 8'h00;
    end else begin
      cmp_raw_o      <= raw_cmd_i;
      tmr_edge_sel_o <= edge_cmd_i;
      if (cap_evt_i && cap_mask_i) begin
        cap_cnt_o <= cap_cnt_o + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ### ccc_pkg.sv
// Constants and carrier types for the comparator control block
package ccc_pkg;
  localparam int CCC_NCH = 4;
  // Register offsets
  localparam logic [2:0] CCC_OFF_CTRL0  = 3'h0;
  localparam logic [2:0] CCC_OFF_STATUS = 3'h4;
  localparam logic [2:0] CCC_OFF_MASK   = 3'h5;
  // Control register fields
  localparam int CCC_EN     = 7;
  localparam int CCC_IE     = 6;
  localparam int CCC_ES_HI  = 5;
  localparam int CCC_ES_LO  = 4;
  localparam int CCC_BIT3   = 3;
  localparam int CCC_NEG_HI = 2;
  // Status and mask: flags sit above the output bits
  localparam int CCC_FLAG_LSB = 4;
  // Reset values
  localparam logic [7:0] CCC_CTRL_RST = 8'h00;
  localparam logic [7:0] CCC_STAT_RST = 8'h00;
  localparam logic [3:0] CCC_MASK_RST = 4'h0;
  // Write masks: bit 3 exists only on channels 0 and 1
  localparam logic [7:0] CCC_WMASK_LO = 8'hFF;
  localparam logic [7:0] CCC_WMASK_HI = 8'hF7;
  // Edge select codes
  localparam logic [1:0] CCC_ES_TOGGLE = 2'h0;
  localparam logic [1:0] CCC_ES_RSVD   = 2'h1;
  localparam logic [1:0] CCC_ES_FALL   = 2'h2;
  localparam logic [1:0] CCC_ES_RISE   = 2'h3;
  // Negative input select codes
  localparam logic [2:0] CCC_NEG_REF_6P40 = 3'h0;
  localparam logic [2:0] CCC_NEG_REF_3P20 = 3'h1;
  localparam logic [2:0] CCC_NEG_REF_2P13 = 3'h2;
  localparam logic [2:0] CCC_NEG_REF_1P60 = 3'h3;
  localparam logic [2:0] CCC_NEG_BANDGAP  = 3'h4;
  localparam logic [2:0] CCC_NEG_DAC      = 3'h5;
  localparam logic [2:0] CCC_NEG_PIN      = 3'h6;
  localparam logic [2:0] CCC_NEG_RSVD     = 3'h7;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } ccc_req_t;

  typedef struct packed {
    logic       en;
    logic [2:0] neg_sel;
    logic       pos_amp;
    logic       clk_amp2x;
  } ccc_ana_t;
endpackage

// ### ccc_top.sv
// Digital control of the clocked comparator channels
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Four channels, output high when positive wins
// - Each channel raises its own interrupt
// - Interrupt flags exported as conversion triggers
// - Status register holds outputs and flags
// - Control bit 7 enables the comparator
// - Control bit 6 enables the channel interrupt, the mask register gates irq_o
// - Edge select: toggle, reserved, fall, rise
// - Channel 0 bit 3 picks PLL clock
// - Three-bit code picks the negative input
// - Amplifier link feeds positive, doubles clock
// - Channel 1 bit 3 routes to capture
// - Timer edge bit picks capture edge
// - Routing off isolates capture logic completely
// - Flag clears on vector or written one
module ccc_top #(
  parameter int NCH = 4
) (
  input  wire logic                     clk_i,
  input  wire logic                     rstn_i,
  input  wire ccc_pkg::ccc_req_t        req_i,
  output logic [7:0]                    rdata_o,
  input  wire logic [NCH-1:0]           cmp_raw_i,
  input  wire logic [2:0]               amp_link_i,
  input  wire logic [NCH-1:0]           irq_ack_i,
  input  wire logic                     tmr_edge_sel_i,
  output ccc_pkg::ccc_ana_t [NCH-1:0]   ana_o,
  output logic                          pll_clk_sel_o,
  output logic [NCH-1:0]                ch_irq_o,
  output logic [NCH-1:0]                trig_o,
  output logic                          irq_o,
  output logic                          cap_level_o,
  output logic                          cap_evt_o
);
  import ccc_pkg::*;

  if (NCH < 2 || NCH > CCC_NCH) begin : g_bad_nch
    $error("NCH must lie between 2 and 4");
  end

  logic [7:0]     ctrl_r [NCH];
  logic [7:0]     ctrl_nxt [NCH];
  logic [NCH-1:0] s1_r;
  logic [NCH-1:0] s2_r;
  logic [NCH-1:0] out_r;
  logic [NCH-1:0] flag_r;
  logic [3:0]     mask_r;
  logic [7:0]     rdata_r;
  logic [NCH-1:0] ch_irq_r;
  logic [NCH-1:0] trig_r;
  logic           irq_r;
  logic           pll_sel_r;
  logic           cap_lvl_r;
  logic           cap_evt_r;
  ccc_ana_t       ana_r [NCH];
  ccc_ana_t       ana_nxt [NCH];

  wire            wr_stat = req_i.wr && req_i.addr == CCC_OFF_STATUS;
  wire            wr_mask = req_i.wr && req_i.addr == CCC_OFF_MASK;
  wire [NCH-1:0]  out_nxt;
  wire [NCH-1:0]  rise_w;
  wire [NCH-1:0]  fall_w;
  wire [NCH-1:0]  evt_w;
  wire [NCH-1:0]  flag_nxt;
  wire [NCH-1:0]  ie_w;
  wire [NCH-1:0]  en_w;
  wire [NCH-1:0]  code_ok;

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    localparam logic [2:0] OFF = CCC_OFF_CTRL0 + 3'(i);
    localparam logic [7:0] WM  = (i < 2) ? CCC_WMASK_LO
                                         : CCC_WMASK_HI;
    wire       wr_ctl = req_i.wr && req_i.addr == OFF;
    wire [1:0] es     = ctrl_r[i][CCC_ES_HI:CCC_ES_LO];
    wire       clr;
    wire       amp;
    assign ctrl_nxt[i] = wr_ctl ? (req_i.wdata & WM) : ctrl_r[i];
    assign en_w[i]     = ctrl_r[i][CCC_EN];
    assign ie_w[i]     = ctrl_r[i][CCC_IE];
    // Reserved code has no defined threshold, so hold low
    // negative select check
    assign code_ok[i] = ctrl_r[i][CCC_NEG_HI:0] != CCC_NEG_RSVD;
    assign out_nxt[i] = en_w[i] & code_ok[i] & s2_r[i];
    assign rise_w[i] = out_nxt[i] & ~out_r[i];
    assign fall_w[i] = ~out_nxt[i] & out_r[i];
    assign evt_w[i] = (es == CCC_ES_TOGGLE) ? (rise_w[i] | fall_w[i])
                    : (es == CCC_ES_RISE)   ? rise_w[i]
                    : (es == CCC_ES_FALL)   ? fall_w[i]
                    : 1'b0;
    assign clr = (wr_stat & req_i.wdata[CCC_FLAG_LSB + i])
               | (irq_ack_i[i] & ie_w[i]);
    // Set beats clear so no event is lost
    assign flag_nxt[i] = evt_w[i] | (flag_r[i] & ~clr);
    // amplifier link on channels 0 to 2
    if (i < 3) begin : g_amp
      assign amp = amp_link_i[i];
    end else begin : g_noamp
      assign amp = 1'b0;
    end
    // code forwarded to the analog mux
    assign ana_nxt[i] = '{en:        ctrl_nxt[i][CCC_EN],
                          neg_sel:   ctrl_nxt[i][CCC_NEG_HI:0],
                          pos_amp:   amp,
                          clk_amp2x: amp};
    assign ana_o[i] = ana_r[i];
  end

  // Register read path
  wire [3:0] out_pad  = 4'(out_r);
  wire [3:0] flag_pad = 4'(flag_r);
  wire [7:0] stat_w   = {flag_pad, out_pad};
  wire       rd_ctl   = req_i.addr < 3'(NCH);
  wire [7:0] ctl_rd   = rd_ctl ? ctrl_r[req_i.addr[1:0]] : 8'h00;
  wire [7:0] rd_mux   = (req_i.addr == CCC_OFF_STATUS) ? stat_w
                      : (req_i.addr == CCC_OFF_MASK)
                        ? {mask_r, 4'h0}
                      : ctl_rd;
  wire [3:0] mask_nxt = wr_mask ? req_i.wdata[7:4] : mask_r;
  wire [NCH-1:0] msk_w = mask_r[NCH-1:0];

  // Capture path, channel 1 only
  wire route = ctrl_r[1][CCC_BIT3];
  // timer edge bit selects the capture edge
  wire cap_edge = tmr_edge_sel_i ? rise_w[1] : fall_w[1];

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int k = 0; k < NCH; k++) begin
        ctrl_r[k] <= CCC_CTRL_RST;
        ana_r[k]  <= '0;
      end
      mask_r <= CCC_MASK_RST;
    end else begin
      for (int k = 0; k < NCH; k++) begin
        ctrl_r[k] <= ctrl_nxt[k];
        ana_r[k]  <= ana_nxt[k];
      end
      mask_r <= mask_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_r  <= '0;
      s2_r  <= '0;
      out_r <= '0;
    end else begin
      s1_r  <= cmp_raw_i;
      s2_r  <= s1_r;
      out_r <= out_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flag_r   <= '0;
      ch_irq_r <= '0;
      trig_r   <= '0;
      irq_r    <= 1'b0;
    end else begin
      flag_r   <= flag_nxt;
      ch_irq_r <= flag_nxt & ie_w;
      trig_r   <= flag_nxt;
      irq_r    <= |(flag_nxt & msk_w);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pll_sel_r <= 1'b0;
      cap_lvl_r <= 1'b0;
      cap_evt_r <= 1'b0;
    end else begin
      pll_sel_r <= ctrl_nxt[0][CCC_BIT3];
      cap_lvl_r <= route & out_nxt[1];
      cap_evt_r <= route & cap_edge;
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_r <= CCC_STAT_RST;
    end else begin
      rdata_r <= req_i.rd ? rd_mux : 8'h00;
    end
  end

  assign rdata_o       = rdata_r;
  assign ch_irq_o      = ch_irq_r;
  assign trig_o        = trig_r;
  assign irq_o         = irq_r;
  assign pll_clk_sel_o = pll_sel_r;
  assign cap_level_o   = cap_lvl_r;
  assign cap_evt_o     = cap_evt_r;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence seq_raw_held;
    (cmp_raw_i[0] && en_w[0] && code_ok[0]) [*3];
  endsequence

  sequence seq_rise_armed;
    ctrl_r[0][CCC_ES_HI:CCC_ES_LO] == CCC_ES_RISE && rise_w[0];
  endsequence

  a_read_status: assert property (
    req_i.rd && req_i.addr == CCC_OFF_STATUS
      |=> rdata_o == $past(stat_w))
    else $error("status read data wrong");

  a_enable_gates: assert property (
    !en_w[0] |=> !out_r[0])
    else $error("disabled comparator shows high");

  a_sync_delay: assert property (
    seq_raw_held |=> out_r[0])
    else $error("output missed after synchroniser");

  a_flag_rise: assert property (
    seq_rise_armed |=> flag_r[0] ##1 trig_o[0])
    else $error("rising edge did not set flag");

  a_rsvd_quiet: assert property (
    ctrl_r[0][CCC_ES_HI:CCC_ES_LO] == CCC_ES_RSVD && !flag_r[0]
      |=> !flag_r[0])
    else $error("reserved edge code set flag");

  a_irq_gate: assert property (
    ch_irq_o[0] |-> $past(ie_w[0]) && $past(flag_nxt[0]))
    else $error("channel irq without enable");

  a_w1c_clear: assert property (
    wr_stat && req_i.wdata[CCC_FLAG_LSB] && !evt_w[0]
      |=> !flag_r[0])
    else $error("written one did not clear flag");

  a_cap_isolated: assert property (
    !route |=> !cap_evt_o && !cap_level_o)
    else $error("capture fed while routing off");

  a_cap_edge: assert property (
    route && !tmr_edge_sel_i && fall_w[1] |=> cap_evt_o)
    else $error("falling capture edge missed");

  a_clk_select: assert property (
    $rose(ctrl_r[0][CCC_BIT3]) |-> pll_clk_sel_o)
    else $error("clock select not following");

endmodule
`default_nettype wire

// ### clocked_comparator_control_tb_top.sv
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module clocked_comparator_control_tb_top;
  import ccc_pkg::*;
  logic                  clk;
  logic                  rstn;
  ccc_req_t              req;
  logic [7:0]            rdata;
  logic [3:0]            raw_cmd;
  logic                  edge_cmd;
  logic [3:0]            cmp_raw;
  logic                  tmr_edge;
  logic [2:0]            amp_link;
  logic [3:0]            irq_ack;
  ccc_ana_t [3:0]        ana;
  logic                  pll_sel;
  logic [3:0]            ch_irq;
  logic [3:0]            trig;
  logic                  irq;
  logic                  cap_level;
  logic                  cap_evt;
  logic [7:0]            cap_cnt;
  logic                  cap_mask;
  int                    err_total = 0;
  int                    n_checks = 0;

  ccc_top #(.NCH(4)) DUT (.clk_i(clk), .rstn_i(rstn), .req_i(req),
    .rdata_o(rdata), .cmp_raw_i(cmp_raw), .amp_link_i(amp_link),
    .irq_ack_i(irq_ack), .tmr_edge_sel_i(tmr_edge), .ana_o(ana),
    .pll_clk_sel_o(pll_sel), .ch_irq_o(ch_irq), .trig_o(trig),
    .irq_o(irq), .cap_level_o(cap_level), .cap_evt_o(cap_evt));
  ccc_far_model far (.clk_i(clk), .rstn_i(rstn), .raw_cmd_i(raw_cmd),
    .edge_cmd_i(edge_cmd), .cap_mask_i(cap_mask), .cap_evt_i(cap_evt),
    .cmp_raw_o(cmp_raw), .tmr_edge_sel_o(tmr_edge), .cap_cnt_o(cap_cnt));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Strobe lowered, then one edge idle so no double drive
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask

  task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e);
  endtask

  task automatic t_regs;
    rdchk(CCC_OFF_CTRL0, CCC_CTRL_RST);
    rdchk(CCC_OFF_STATUS, CCC_STAT_RST);
    rdchk(3'h6, 8'h00);
    wr(CCC_OFF_CTRL0, 8'hCD);
    rdchk(CCC_OFF_CTRL0, 8'hCD);
    chk(8'({ana[0].en, ana[0].neg_sel}), 8'h0D);
    chk(8'(pll_sel), 8'h01);
    chk(8'({ana[0].pos_amp, ana[0].clk_amp2x, ana[1].pos_amp,
            ana[2].pos_amp, ana[3].pos_amp}), 8'h1A);
    // Code 7 holds the output low
    wr(3'h2, 8'hFF);
    rdchk(3'h2, 8'hF7);
    raw_cmd[2] <= 1'b1;
    cyc(6);
    rdchk(CCC_OFF_STATUS, 8'h00);
  endtask

  task automatic t_edges;
    logic [7:0] d;
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      wr(CCC_OFF_CTRL0, {2'b10, c, 4'h0});
      wr(CCC_OFF_STATUS, 8'hF0);
      raw_cmd[0] <= 1'b1;
      cyc(6);
      rd(CCC_OFF_STATUS, d);
      chk(8'(d[0]), 8'h01);
      chk(8'(d[4]), 8'(c == 2'h3 || c == 2'h0));
      wr(CCC_OFF_STATUS, 8'hF0);
      raw_cmd[0] <= 1'b0;
      cyc(6);
      rd(CCC_OFF_STATUS, d);
      chk(8'(d[4]), 8'(c == 2'h2 || c == 2'h0));
    end
  endtask

  task automatic t_irq;
    wr(CCC_OFF_CTRL0, 8'hF0);
    wr(CCC_OFF_MASK, 8'h10);
    raw_cmd[0] <= 1'b1;
    cyc(6);
    chk(8'({ch_irq[0], trig[0], irq}), 8'h07);
    irq_ack[0] <= 1'b1;
    @(posedge clk);
    irq_ack[0] <= 1'b0;
    cyc(3);
    chk(8'(trig[0]), 8'h00);
    raw_cmd[0] <= 1'b0;
    cyc(6);
    raw_cmd[0] <= 1'b1;
    cyc(6);
    wr(CCC_OFF_MASK, 8'h00);
    cyc(2);
    chk(8'({ch_irq[0], irq}), 8'h02);
    wr(CCC_OFF_STATUS, 8'h10);
    cyc(2);
    chk(8'({ch_irq[0], trig[0]}), 8'h00);
  endtask

  task automatic t_cap;
    wr(3'h1, 8'h88);
    // Edge bit settles before the edge, rising pass then falling pass
    for (int i = 0; i < 2; i++) begin
      edge_cmd <= (i == 0);
      raw_cmd[1] <= 1'b1;
      cyc(6);
      chk(8'(cap_level), 8'h01);
      raw_cmd[1] <= 1'b0;
      cyc(6);
      chk(cap_cnt, 8'(i + 1));
    end
    // Timer mask off: routed edges must not count
    cap_mask <= 1'b0;
    raw_cmd[1] <= 1'b1;
    cyc(6);
    raw_cmd[1] <= 1'b0;
    cyc(6);
    chk(cap_cnt, 8'h02);
    cap_mask <= 1'b1;
    wr(3'h1, 8'h80);
    raw_cmd[1] <= 1'b1;
    cyc(6);
    chk(8'(cap_level), 8'h00);
    raw_cmd[1] <= 1'b0;
    cyc(6);
    chk(cap_cnt, 8'h02);
  endtask

  // Watchdog against a hung sequence
  initial begin
    #200000;
    err_total++;
    complete_run();
  end

  initial begin
    rstn = 1'b0;
    req = '0;
    raw_cmd = 4'h0;
    edge_cmd = 1'b0;
    cap_mask = 1'b1;
    amp_link = 3'b101;
    irq_ack = 4'h0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_edges();
    t_irq();
    t_cap();
    complete_run();
  end
endmodule
`default_nettype wire
